// file: adc_autozero_gain_control.sv
// offset-cancel sequencer, gain decode and result datapath of the converter
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
//
// Behaviour
// R1 - offset cancel enable resets to 0; then conversions run without it
// R2 - enabled: each result uses a normal-polarity then a swapped-polarity conversion
// R3 - enabled: output is normal result minus swapped result, halved
// R4 - enabled: total conversion time is twice the plain conversion time
// R5 - enabled with continuous mode: filter is reset between every conversion
// R6 - that case runs back-to-back single conversions with no gap
// R7 - gain codes 000 to 101 set analog gain, digital gain stays 1
// R8 - codes 110 and 111 keep analog 16, add digital 2 and 4
// R9 - digital gain is a left shift with rounding, limited to 1x to 4x
// R10 - digital gain sits inside the filter datapath, after the modulator
// R11 - quantizer word is thermometer code from four comparators, five levels
// R12 - modulator word is refreshed every modulator sample clock
// R13 - words 1111,0111,0011,0001,0000 decode to +2,+1,0,-1,-2
// R14 - first-polarity result is held; only the combined result is presented
module adc_autozero_gain_control
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [3:0] comparator_word,
  output logic input_swap,
  output logic [2:0] analog_gain_select,
  output logic conversion_busy,
  output logic result_valid,
  output logic [RESULT_W-1:0] result_data
);
  // configuration and state
  logic offset_cancel_enable;
  logic [1:0] conversion_mode_select;
  logic [2:0] gain_select;
  conv_state_t state;
  logic [CNT_W-1:0] sample_count;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] first_sum;
  logic cancel_active;
  logic second_phase;
  logic data_ready;
  logic [3:0] comp_meta;
  logic [3:0] comp_sync;
  logic signed [2:0] sample_level;
  logic [7:0] elapsed;

  // the comparator word arrives from the analog side, so sync it first
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      comp_meta <= THERMO_Z;
      comp_sync <= THERMO_Z;
    end else begin
      comp_meta <= comparator_word;
      comp_sync <= comp_meta;
    end
  end

  // one level per modulator sample clock
  thermo_level_decode u_level_decode (
    .ref_clk(ref_clk),
    .reset(reset),
    .thermo_word(comp_sync), // R11 R12
    .level(sample_level)
  );

  // bus decode
  wire ctrl_write = wr_strobe && (addr == CTRL_ADDR);
  wire start_req = ctrl_write && wr_data[CTRL_START_BIT];
  wire result_read = rd_strobe && (addr == RESULT_ADDR);
  wire continuous = (conversion_mode_select == MODE_CONTINUOUS);
  // a start written together with the cancel bit must run with that same setting
  wire next_cancel = ctrl_write ? wr_data[CTRL_CANCEL_BIT] : offset_cancel_enable;

  // sequencing decode
  wire last_sample = (state == ST_CONVERT) && (sample_count == SAMPLE_LAST);
  wire first_done = last_sample && cancel_active && !second_phase; // R2
  wire final_done = last_sample && !(cancel_active && !second_phase); // R4
  wire launch = (state == ST_IDLE) && (start_req || continuous);
  // a new conversion starts right after the last one in continuous mode
  wire relaunch = final_done && continuous; // R5 R6

  // datapath: running sum including the sample of this cycle
  wire signed [ACC_W-1:0] last_sum = acc + ACC_W'(sample_level);
  // plain mode doubles the sum so one halving step serves both modes
  wire signed [ACC_W:0] numer = cancel_active ?
    ((ACC_W+1)'(first_sum) - (ACC_W+1)'(last_sum)) : // R3
    ((ACC_W+1)'(last_sum) <<< 1); // R1

  // digital gain decode; analog gain never rises past the top analog code
  wire [1:0] digital_shift = (gain_select == GAIN_X64) ? SHIFT_X4 : // R8
                             (gain_select == GAIN_X32) ? SHIFT_X2 : SHIFT_X1; // R7
  wire [2:0] next_analog_gain = (gain_select > GAIN_ANALOG_MAX) ?
                                GAIN_ANALOG_MAX : gain_select; // R7 R8

  // shift left then round the halving, inside the filter output path
  wire signed [ACC_W+2:0] scaled = (ACC_W+3)'(numer) <<< digital_shift; // R9 R10
  wire signed [ACC_W+2:0] rounded = (scaled + (ACC_W+3)'(1)) >>> 1; // R3 R9
  wire [RESULT_W-1:0] next_result = RESULT_W'(rounded);

  // read mux, only the cycle after a read strobe carries data
  wire [DATA_W-1:0] ctrl_word = DATA_W'({gain_select, conversion_mode_select,
                                         offset_cancel_enable});
  wire [DATA_W-1:0] status_word = DATA_W'({second_phase, data_ready,
                                           (state == ST_CONVERT)});
  wire [DATA_W-1:0] next_rd_data =
    !rd_strobe ? '0 :
    (addr == CTRL_ADDR) ? ctrl_word :
    (addr == STATUS_ADDR) ? status_word :
    (addr == RESULT_ADDR) ? DATA_W'(result_data) :
    (addr == LEVEL_ADDR) ? DATA_W'(comp_sync) : '0;

  // software configuration
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      offset_cancel_enable <= CANCEL_RESET; // R1
      conversion_mode_select <= MODE_RESET;
      gain_select <= GAIN_RESET;
    end else if (ctrl_write) begin
      offset_cancel_enable <= wr_data[CTRL_CANCEL_BIT];
      conversion_mode_select <= wr_data[CTRL_MODE_LSB +: 2];
      gain_select <= wr_data[CTRL_GAIN_LSB +: 3];
    end
  end

  // conversion state; the cancel setting is frozen per conversion, the mode is read live at each end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      cancel_active <= 1'b0;
    end else if (launch || relaunch) begin
      state <= ST_CONVERT;
      cancel_active <= next_cancel; // R1 R2
    end else if (final_done) begin
      state <= ST_IDLE;
    end
  end

  // sample counter and integrate-and-dump filter, cleared at each start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sample_count <= '0;
      acc <= '0;
    end else if (launch || relaunch || first_done) begin
      sample_count <= '0; // R5
      acc <= '0; // R5
    end else if (state == ST_CONVERT) begin
      sample_count <= sample_count + 1'b1;
      acc <= last_sum;
    end
  end

  // polarity phase; the first sum is held back until the pair completes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      second_phase <= 1'b0;
      input_swap <= 1'b0;
      first_sum <= '0;
    end else if (first_done) begin
      second_phase <= 1'b1;
      input_swap <= 1'b1; // R2
      first_sum <= last_sum; // R14
    end else if (final_done || launch) begin
      second_phase <= 1'b0;
      input_swap <= 1'b0;
    end
  end

  // result output: presented once per completed result only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_valid <= 1'b0;
      result_data <= '0;
    end else begin
      result_valid <= final_done; // R14
      if (final_done) begin
        result_data <= next_result; // R3 R14
      end
    end
  end

  // ready flag: a new result in the same cycle as a read keeps it set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data_ready <= 1'b0;
    end else if (final_done) begin
      data_ready <= 1'b1;
    end else if (result_read) begin
      data_ready <= 1'b0;
    end
  end

  // registered outputs toward the analog side and the bus
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      analog_gain_select <= GAIN_RESET;
      conversion_busy <= 1'b0;
      rd_data <= '0;
    end else begin
      analog_gain_select <= next_analog_gain; // R7 R8
      conversion_busy <= (launch || relaunch) || (state == ST_CONVERT && !final_done);
      rd_data <= next_rd_data;
    end
  end

  // checking helper: cycles spent since the current conversion started
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      elapsed <= '0;
    end else if (launch || relaunch) begin
      elapsed <= '0;
    end else if (state == ST_CONVERT) begin
      elapsed <= elapsed + 1'b1;
    end
  end

  localparam int PLAIN_LAST = CONV_SAMPLES - 1;
  localparam int PAIR_LAST = 2 * CONV_SAMPLES - 1;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_first_half_end;
    first_done;
  endsequence

  sequence s_swapped_phase;
    input_swap && second_phase;
  endsequence

  a_plain_no_swap: assert property ( // R1
    (state == ST_CONVERT && !cancel_active) |-> !input_swap && !second_phase)
    else $error("swap seen while offset cancel is off");

  a_pair_swap_order: assert property ( // R2
    s_first_half_end |=> s_swapped_phase ##1 (input_swap [*8]))
    else $error("second conversion did not run swapped");

  a_pair_result_value: assert property ( // R3
    (final_done && cancel_active && digital_shift == SHIFT_X1) |=>
      (result_data == RESULT_W'(($past(first_sum) - $past(last_sum)
        + (ACC_W+3)'(1)) >>> 1)))
    else $error("combined result is not half the difference");

  a_conv_duration: assert property ( // R4
    final_done |-> (elapsed == (cancel_active ? PAIR_LAST : PLAIN_LAST)))
    else $error("conversion length wrong");

  a_cont_restart: assert property ( // R5
    (final_done && continuous) |=> (state == ST_CONVERT && sample_count == '0 && acc == '0))
    else $error("filter not reset between continuous conversions");

  a_cont_no_gap: assert property ( // R6
    (result_valid && $past(continuous)) |-> conversion_busy)
    else $error("gap between back to back conversions");

  a_analog_gain_map: assert property ( // R7
    ##1 (analog_gain_select == (($past(gain_select) > GAIN_ANALOG_MAX) ?
      GAIN_ANALOG_MAX : $past(gain_select))))
    else $error("analog gain decode wrong");

  a_digital_gain_map: assert property ( // R8
    (gain_select == GAIN_X64) |-> (digital_shift == SHIFT_X4) ##0
      (next_analog_gain == GAIN_ANALOG_MAX))
    else $error("top gain code not analog 16 with digital 4");

  a_level_decode: assert property ( // R13
    (comp_sync == THERMO_M1) |=> (sample_level == LEVEL_M1))
    else $error("thermometer word decoded wrongly");

  a_single_presentation: assert property ( // R14
    (result_valid && $past(cancel_active)) |-> $past(second_phase))
    else $error("result presented before swapped conversion");

  // results, polarity hold, level and gain ends and restart, seen from outputs and internal state
  a_plain_result_value: assert property ( // R1 R9
    (final_done && !cancel_active) |=>
      (result_data == (RESULT_W'($past(last_sum)) << $past(digital_shift))))
    else $error("plain result is not the shifted sum");

  a_first_sum_hold: assert property ( // R14
    (second_phase && $past(second_phase)) |-> $stable(first_sum))
    else $error("held first result moved during swapped conversion");

  a_level_ends: assert property ( // R13
    (comp_sync == THERMO_P2 || comp_sync == THERMO_M2) |=>
      (sample_level == (($past(comp_sync) == THERMO_P2) ? LEVEL_P2 : LEVEL_M2)))
    else $error("end thermometer word decoded wrongly");

  a_x32_gain_map: assert property ( // R8
    (gain_select == GAIN_X32) |-> (digital_shift == SHIFT_X2) ##1
      (analog_gain_select == GAIN_ANALOG_MAX))
    else $error("gain code 110 not analog 16 with digital 2");

  a_swap_released: assert property ( // R2
    (result_valid && $past(cancel_active)) |-> !input_swap)
    else $error("inputs still swapped after the pair completed");

  a_cont_fresh_start: assert property ( // R6
    (final_done && continuous) |=> (elapsed == '0 && conversion_busy && !second_phase))
    else $error("continuous restart is not a fresh single conversion");
endmodule

// file: adc_ctrl_pkg.sv
// shared constants and types for the converter control block
package adc_ctrl_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] LEVEL_ADDR = 8'h0C;

  // control word fields
  localparam int CTRL_CANCEL_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_GAIN_LSB = 3;
  localparam int CTRL_START_BIT = 6;

  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;

  // reset values
  localparam logic CANCEL_RESET = 1'b0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] GAIN_RESET = 3'h1;

  // conversion mode and gain encodings
  localparam logic [1:0] MODE_CONTINUOUS = 2'h3;
  localparam logic [2:0] GAIN_ANALOG_MAX = 3'h5;
  localparam logic [2:0] GAIN_X32 = 3'h6;
  localparam logic [2:0] GAIN_X64 = 3'h7;
  localparam logic [1:0] SHIFT_X1 = 2'h0;
  localparam logic [1:0] SHIFT_X2 = 2'h1;
  localparam logic [1:0] SHIFT_X4 = 2'h2;

  // thermometer comparator words and their levels
  localparam logic [3:0] THERMO_P2 = 4'hF;
  localparam logic [3:0] THERMO_P1 = 4'h7;
  localparam logic [3:0] THERMO_Z = 4'h3;
  localparam logic [3:0] THERMO_M1 = 4'h1;
  localparam logic [3:0] THERMO_M2 = 4'h0;
  localparam logic signed [2:0] LEVEL_P2 = 3'sh2;
  localparam logic signed [2:0] LEVEL_P1 = 3'sh1;
  localparam logic signed [2:0] LEVEL_Z = 3'sh0;
  localparam logic signed [2:0] LEVEL_M1 = -3'sh1;
  localparam logic signed [2:0] LEVEL_M2 = -3'sh2;

  // datapath widths and conversion length in modulator samples
  localparam int CNT_W = 6;
  localparam int ACC_W = 10;
  localparam int RESULT_W = 24;
  localparam int CONV_SAMPLES = 64;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = 6'h3F;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01
  } conv_state_t;
endpackage

// file: thermo_level_decode.sv
// registered thermometer word to signed level decoder
`timescale 1ns/10ps
module thermo_level_decode
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] thermo_word,
  output logic signed [2:0] level
);
  logic signed [2:0] next_level;

  // known codes map by table; a broken code counts its ones, minus two
  always_comb begin
    unique case (thermo_word)
      THERMO_P2: next_level = LEVEL_P2; // R13
      THERMO_P1: next_level = LEVEL_P1; // R13
      THERMO_Z: next_level = LEVEL_Z; // R13
      THERMO_M1: next_level = LEVEL_M1; // R13
      THERMO_M2: next_level = LEVEL_M2; // R13
      default: next_level = 3'($countones(thermo_word)) + LEVEL_M2;
    endcase
  end

  // refreshed on every modulator sample
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level <= LEVEL_Z;
    end else begin
      level <= next_level; // R12
    end
  end
endmodule

// file: modulator_model.sv
// behavioural comparator bank standing in front of the control block
`timescale 1ns/10ps
module modulator_model (
  input wire logic ref_clk,
  input wire logic input_swap,
  input wire logic signed [2:0] signal_level,
  input wire logic signed [2:0] offset_level,
  output logic [3:0] comparator_word
);
  logic signed [3:0] sig;
  logic signed [3:0] next_level;
  // swapping the inputs negates the signal, the front-end offset stays put
  assign sig = 4'(signal_level);
  assign next_level = (input_swap ? -sig : sig) + 4'(offset_level);
  // four comparators, equal steps, thermometer coded; saturates at the ends
  function automatic logic [3:0] thermo(input logic signed [3:0] lvl);
    if (lvl >= 4'sd2) return 4'hF;
    if (lvl == 4'sd1) return 4'h7;
    if (lvl == 4'sd0) return 4'h3;
    if (lvl == -4'sd1) return 4'h1;
    return 4'h0;
  endfunction
  // a fresh word on every modulator sample edge
  always_ff @(posedge ref_clk) begin
    comparator_word <= thermo(next_level);
  end
endmodule

// file: adc_autozero_gain_control_bench.sv
// self-checking bench for the offset-cancel and gain control block
`timescale 1ns/10ps
module adc_autozero_gain_control_bench
  import adc_ctrl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [3:0] comparator_word;
  logic input_swap;
  logic [2:0] analog_gain_select;
  logic conversion_busy;
  logic result_valid;
  logic [RESULT_W-1:0] result_data;
  logic signed [2:0] signal_level = 3'sh0;
  logic signed [2:0] offset_level = 3'sh1;
  logic swap_hist [0:300];
  logic [31:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  always #25 ref_clk = ~ref_clk;

  adc_autozero_gain_control dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .comparator_word(comparator_word), .input_swap(input_swap),
    .analog_gain_select(analog_gain_select), .conversion_busy(conversion_busy),
    .result_valid(result_valid), .result_data(result_data));

  modulator_model front (.ref_clk(ref_clk), .input_swap(input_swap),
    .signal_level(signal_level), .offset_level(offset_level),
    .comparator_word(comparator_word));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang costs a mismatch rather than the whole run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; returns on the edge that takes the request
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // edges counted from the launching edge to the result pulse, swap logged
  task automatic wait_result(output int cnt);
    cnt = 0;
    while (cnt < 300) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      swap_hist[cnt] = input_swap;
      if (result_valid === 1'b1) break;
    end
  endtask

  task automatic convert(input logic [31:0] ctrl, input int exp_cnt, input logic [23:0] exp);
    // a changed model input needs the model flop, sync and decode before it counts
    repeat (3) @(posedge ref_clk);
    write_reg(CTRL_ADDR, ctrl | 32'h40);
    wait_result(n);
    check(32'(n), 32'(exp_cnt));
    check({8'h00, result_data}, {8'h00, exp});
  endtask

  task automatic test_reset();
    read_reg(CTRL_ADDR, rd);
    check(rd, 32'h08);
    check({29'h0, analog_gain_select}, 32'h1);
    check({31'h0, input_swap}, 32'h0);
    read_reg(LEVEL_ADDR, rd);
    check(rd, 32'h7);
    read_reg(8'h10, rd);
    check(rd, 32'h0);
    @(posedge ref_clk);
    #1;
    check(rd_data, 32'h0);
    $display("test reset done");
  endtask

  // every thermometer level, cancel off, unity gain: sum of 64 samples
  task automatic test_levels();
    offset_level = 3'sh0;
    for (int i = -2; i <= 2; i++) begin
      signal_level = 3'(i);
      convert(32'h08, 64, 24'(64 * i));
    end
    $display("test levels done");
  endtask

  task automatic test_gain();
    signal_level = 3'sh1;
    for (int g = 0; g < 8; g++) begin
      convert(32'(g) << 3, 64, 24'(64 << (g == 6 ? 1 : g == 7 ? 2 : 0)));
      check({29'h0, analog_gain_select}, 32'(g > 5 ? 5 : g));
    end
    $display("test gain done");
  endtask

  task automatic test_cancel();
    signal_level = 3'sh0;
    offset_level = 3'sh1;
    convert(32'h09, 128, 24'h0);
    check({31'h0, swap_hist[63]}, 32'h0);
    check({31'h0, swap_hist[64]}, 32'h1);
    check({31'h0, swap_hist[127]}, 32'h1);
    check({31'h0, swap_hist[128]}, 32'h0);
    read_reg(STATUS_ADDR, rd);
    check(rd, 32'h2);
    read_reg(RESULT_ADDR, rd);
    check(rd, 32'h0);
    read_reg(STATUS_ADDR, rd);
    check(rd, 32'h0);
    offset_level = -3'sh1;
    convert(32'h39, 128, 24'h0);
    // a signal survives the difference; four swapped samples still lag at +1
    signal_level = 3'sh1;
    offset_level = 3'sh0;
    convert(32'h09, 128, 24'h3C);
    n_tests++;
    if ($isunknown(result_data) || $signed(result_data) < 58 || $signed(result_data) > 64) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, result_data, 24'h40);
    end
    $display("test cancel done");
  endtask

  // continuous mode: cancel on gives two-conversion periods, off gives one
  task automatic test_continuous();
    signal_level = 3'sh0;
    offset_level = 3'sh1;
    for (int k = 0; k < 2; k++) begin
      write_reg(CTRL_ADDR, k == 0 ? 32'h0F : 32'h0E);
      wait_result(n);
      wait_result(n);
      check(32'(n), k == 0 ? 32'd128 : 32'd64);
      check({8'h00, result_data}, k == 0 ? 32'h0 : 32'h40);
      wait_result(n);
      check(32'(n), k == 0 ? 32'd128 : 32'd64);
      write_reg(CTRL_ADDR, 32'h08);
      n = 0;
      while (n < 300 && conversion_busy !== 1'b0) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check({31'h0, conversion_busy}, 32'h0);
    end
    $display("test continuous done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    test_reset();
    test_levels();
    test_gain();
    test_cancel();
    test_continuous();
    finish_test();
  end
endmodule
